// ===== pkg/ris_params.svh
// Timing counts and reset values for the reset and start-up sequencer
`ifndef RIS_PARAMS_SVH
`define RIS_PARAMS_SVH
`define RIS_CLK_MHZ 250
`define RIS_SKEW_NS 50
`define RIS_SKEW_CYC ((`RIS_SKEW_NS * `RIS_CLK_MHZ) / 1000)
`define RIS_FPR_MS 100
`define RIS_EE_WORDS 8
`define RIS_EE_IDX_W 3
`define RIS_REFCLK_EN_RST 1'b1
`define RIS_REFCLK_EN_BIT 0
`endif

// ===== pkg/ris_pkg.sv
// Types shared by the reset and start-up sequencer
package ris_pkg;
   typedef enum logic [2:0] {
      RIS_ST_RESET = 3'b000,
      RIS_ST_STRAP = 3'b001,
      RIS_ST_LOAD = 3'b011,
      RIS_ST_ENABLE = 3'b010,
      RIS_ST_RUN = 3'b110,
      RIS_ST_SUSPEND = 3'b111
   } ris_state_e;
   typedef logic [15:0] ris_word_t;
endpackage : ris_pkg

// ===== hw/ris_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ris_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : ris_sync
`default_nettype wire

// ===== hw/ris_seq.sv
// Reset and start-up sequencer for the link bridge
// What this block does
// - Fundamental reset low returns all logic default except suspend flag, skew monitor and most pin synchronisers
// - Sample straps when fundamental reset releases
// - Copy attached EEPROM into configuration registers
// - Reset, load, enable interface, then software
// - Strap low adapter, strap high root complex
// - Adapter enables link port; USB waits software
// - Root complex enables USB; link training after load, link port never
// - Auxiliary reset clears auxiliary-powered circuitry
// - Suspend on USB suspend in root complex mode or D3cold in adapter mode
`timescale 1ns/1ps
`default_nettype none
`include "ris_params.svh"
module ris_seq (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic fundamental_reset_n_i,
   input wire logic aux_power_on_reset_n_i,
   input wire logic root_complex_mode_strap_i,
   input wire logic ee_present_i,
   input wire logic ee_valid_i,
   input wire logic [15:0] ee_data_i,
   input wire logic sw_usb_enable_i,
   input wire logic sw_ref_clock_out_enable_i,
   input wire logic sw_ref_clock_wr_i,
   input wire logic usb_suspend_i,
   input wire logic d3cold_i,
   input wire logic wake_i,
   output logic ee_req_o,
   output logic [2:0] ee_addr_o,
   output logic root_complex_mode_o,
   output logic link_enum_enable_o,
   output logic usb_enum_enable_o,
   output logic link_training_enable_o,
   output logic config_ready_o,
   output logic suspend_o,
   output logic ref_clock_out_enable_o,
   output logic [15:0] cfg_word_o,
   output logic reset_skew_err_o
);
   // ============================================================
   // Input synchronisers
   // The fundamental reset pin joins an async core reset so no core logic runs while it is low
   logic core_rst;
   logic aux_rst;
   logic fund_ok;
   logic aux_ok;
   logic strap_s;
   logic present_s;
   logic suspend_req_s;
   logic wake_s;
   assign core_rst = sys_rst_i | ~fundamental_reset_n_i;
   assign aux_rst = sys_rst_i | ~aux_power_on_reset_n_i;
   ris_sync u_fund (.clk_i(clk_i), .rst_i(aux_rst), .d_i(fundamental_reset_n_i), .q_o(fund_ok));
   ris_sync u_aux (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(aux_power_on_reset_n_i), .q_o(aux_ok));
   // Straps keep tracking their pins through fundamental reset, so the
   // first edge after release already sees settled values
   ris_sync u_strap (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(root_complex_mode_strap_i),
      .q_o(strap_s));
   ris_sync u_pres (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(ee_present_i), .q_o(present_s));
   ris_sync u_susp (.clk_i(clk_i), .rst_i(core_rst),
      .d_i(root_complex_mode_o ? usb_suspend_i : d3cold_i), .q_o(suspend_req_s));
   ris_sync u_wake (.clk_i(clk_i), .rst_i(aux_rst), .d_i(wake_i), .q_o(wake_s));

   // ============================================================
   // Sequencer state
   ris_pkg::ris_state_e state;
   logic [`RIS_EE_IDX_W-1:0] ee_idx;
   logic load_last;
   assign load_last = ee_valid_i && (ee_idx == `RIS_EE_IDX_W'(`RIS_EE_WORDS - 1));

   always_ff @(posedge clk_i or posedge core_rst) begin
      if (core_rst) begin
         state <= ris_pkg::RIS_ST_RESET;
      end else begin
         unique case (state)
            ris_pkg::RIS_ST_RESET: begin
               state <= ris_pkg::RIS_ST_STRAP;
            end
            ris_pkg::RIS_ST_STRAP: begin
               // Skipping the load leaves the default configuration in place
               state <= present_s ? ris_pkg::RIS_ST_LOAD : ris_pkg::RIS_ST_ENABLE;
            end
            ris_pkg::RIS_ST_LOAD: begin
               if (load_last) begin
                  state <= ris_pkg::RIS_ST_ENABLE;
               end
            end
            ris_pkg::RIS_ST_ENABLE: begin
               state <= ris_pkg::RIS_ST_RUN;
            end
            ris_pkg::RIS_ST_RUN: begin
               if (suspend_req_s) begin
                  state <= ris_pkg::RIS_ST_SUSPEND;
               end
            end
            ris_pkg::RIS_ST_SUSPEND: begin
               if (!suspend_req_s) begin
                  state <= ris_pkg::RIS_ST_RUN;
               end
            end
            default: begin
               state <= ris_pkg::RIS_ST_RESET;
            end
         endcase
      end
   end

   // ============================================================
   // Strap capture, clocked after release, never inside the reset
   always_ff @(posedge clk_i or posedge core_rst) begin
      if (core_rst) begin
         root_complex_mode_o <= 1'b0;
      end else if (state == ris_pkg::RIS_ST_RESET) begin
         root_complex_mode_o <= strap_s;
      end
   end

   // ============================================================
   // EEPROM load into the configuration word
   always_ff @(posedge clk_i or posedge core_rst) begin
      if (core_rst) begin
         ee_idx <= '0;
         ee_req_o <= 1'b0;
         ee_addr_o <= '0;
      end else begin
         ee_req_o <= (state == ris_pkg::RIS_ST_LOAD) && !load_last;
         if (state == ris_pkg::RIS_ST_LOAD && ee_valid_i) begin
            ee_idx <= ee_idx + 1'b1;
         end
         ee_addr_o <= (state == ris_pkg::RIS_ST_LOAD && ee_valid_i) ? ee_idx + 1'b1 : ee_idx;
      end
   end

   always_ff @(posedge clk_i or posedge core_rst) begin
      if (core_rst) begin
         cfg_word_o <= 16'h0000;
      end else if (state == ris_pkg::RIS_ST_LOAD && ee_valid_i) begin
         cfg_word_o <= ee_data_i;
      end
   end

   // ============================================================
   // Interface enables
   logic running;
   assign running = (state == ris_pkg::RIS_ST_RUN);
   always_ff @(posedge clk_i or posedge core_rst) begin
      if (core_rst) begin
         link_enum_enable_o <= 1'b0;
         usb_enum_enable_o <= 1'b0;
         link_training_enable_o <= 1'b0;
         config_ready_o <= 1'b0;
      end else begin
         link_enum_enable_o <= running && !root_complex_mode_o;
         // USB stays off in adapter operation until software turns it on
         usb_enum_enable_o <= running && (root_complex_mode_o || sw_usb_enable_i);
         link_training_enable_o <= running;
         config_ready_o <= running;
      end
   end

   // ============================================================
   // Suspend flag lives in the auxiliary domain so wake detection survives
   always_ff @(posedge clk_i or posedge aux_rst) begin
      if (aux_rst) begin
         suspend_o <= 1'b0;
      end else if (state == ris_pkg::RIS_ST_RUN && suspend_req_s) begin
         // Entry lasts one cycle and is tested first, so it wins over a wake in that cycle
         suspend_o <= 1'b1;
      end else if (wake_s) begin
         suspend_o <= 1'b0;
      end
   end

   // ============================================================
   // Reference clock output enable
   always_ff @(posedge clk_i or posedge core_rst) begin
      if (core_rst) begin
         ref_clock_out_enable_o <= `RIS_REFCLK_EN_RST;
      end else if (state == ris_pkg::RIS_ST_LOAD && ee_valid_i) begin
         ref_clock_out_enable_o <= ee_data_i[`RIS_REFCLK_EN_BIT];
      end else if (sw_ref_clock_wr_i) begin
         ref_clock_out_enable_o <= sw_ref_clock_out_enable_i;
      end
   end

   // ============================================================
   // Skew monitor for tied resets; longer mismatch means they are not tied
   logic [7:0] skew_cnt;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         skew_cnt <= 8'h00;
         reset_skew_err_o <= 1'b0;
      end else if (fund_ok != aux_ok) begin
         if (skew_cnt <= 8'(`RIS_SKEW_CYC)) begin
            skew_cnt <= skew_cnt + 8'h01;
         end
         reset_skew_err_o <= (skew_cnt >= 8'(`RIS_SKEW_CYC));
      end else begin
         skew_cnt <= 8'h00;
         reset_skew_err_o <= 1'b0;
      end
   end

   // ============================================================
   // Checks
   sequence s_load_done;
      (state == ris_pkg::RIS_ST_LOAD) && load_last;
   endsequence
   a_load_then_enable: assert property (@(posedge clk_i) disable iff (core_rst)
      s_load_done |=> (state == ris_pkg::RIS_ST_ENABLE) ##1 running ##1 config_ready_o)
      else $error("load did not lead to enable");
   a_skip_load: assert property (@(posedge clk_i) disable iff (core_rst)
      (state == ris_pkg::RIS_ST_STRAP && !present_s) |=> state == ris_pkg::RIS_ST_ENABLE)
      else $error("missing eeprom not skipped");
   a_adapter_no_usb: assert property (@(posedge clk_i) disable iff (core_rst)
      (!root_complex_mode_o && !$past(sw_usb_enable_i)) |-> !usb_enum_enable_o)
      else $error("usb enabled without software");
   a_adapter_link_on: assert property (@(posedge clk_i) disable iff (core_rst)
      (running && !root_complex_mode_o) |=> link_enum_enable_o)
      else $error("adapter link not enabled");
   a_rc_usb_on: assert property (@(posedge clk_i) disable iff (core_rst)
      (running && root_complex_mode_o) |=> usb_enum_enable_o && !link_enum_enable_o)
      else $error("root complex usb not enabled");
   a_no_train_early: assert property (@(posedge clk_i) disable iff (core_rst)
      (state == ris_pkg::RIS_ST_LOAD) |=> !link_training_enable_o)
      else $error("link training before load end");
   a_strap_held: assert property (@(posedge clk_i) disable iff (core_rst)
      (state != ris_pkg::RIS_ST_RESET) |=> $stable(root_complex_mode_o))
      else $error("mode changed after capture");
   a_refclk_sw_off: assert property (@(posedge clk_i) disable iff (core_rst)
      (sw_ref_clock_wr_i && !sw_ref_clock_out_enable_i && state != ris_pkg::RIS_ST_LOAD)
      |=> !ref_clock_out_enable_o)
      else $error("reference clock not disabled");
   a_suspend_entry: assert property (@(posedge clk_i) disable iff (aux_rst)
      (state == ris_pkg::RIS_ST_RUN && suspend_req_s) |=> suspend_o)
      else $error("suspend not entered");
   a_wake_clears: assert property (@(posedge clk_i) disable iff (aux_rst)
      (wake_s && !(state == ris_pkg::RIS_ST_RUN && suspend_req_s)) |=> !suspend_o)
      else $error("wake did not clear suspend");
endmodule : ris_seq
`default_nettype wire

// ===== bench/ris_board_model.sv
// Board side model that answers serial EEPROM word requests
`timescale 1ns/1ps
`default_nettype none
module ris_board_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic [127:0] words_i,
   input wire logic ee_req_i,
   input wire logic [2:0] ee_addr_i,
   output logic ee_valid_o,
   output logic [15:0] ee_data_o
);
   int gap = 0;
   initial begin
      ee_valid_o = 1'b0;
      ee_data_o = 16'h0000;
   end
   // Idle data toggles so a stale word never passes for a fresh one
   always @(negedge clk_i) begin
      if (ee_req_i && gap == 0) begin
         ee_valid_o <= 1'b1;
         ee_data_o <= words_i[16*ee_addr_i +: 16];
         gap <= slow_i ? 3 : 0;
      end else begin
         ee_valid_o <= 1'b0;
         ee_data_o <= ~ee_data_o;
         gap <= (gap > 0) ? gap - 1 : 0;
      end
   end
endmodule : ris_board_model
`default_nettype wire

// ===== bench/reset_init_sequencer_bench.sv
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_init_sequencer_bench;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, frst_n = 1'b0, arst_n = 1'b0;
   logic strap = 1'b0, present = 1'b0, slow = 1'b0, sw_usb = 1'b0, sw_ref = 1'b1;
   logic sw_wr = 1'b0, usb_susp = 1'b0, d3cold = 1'b0, wake = 1'b0, ee_valid;
   logic [15:0] ee_data;
   logic [127:0] words = '0;
   logic ee_req_o, root_complex_mode_o, link_enum_enable_o, usb_enum_enable_o;
   logic link_training_enable_o, config_ready_o, suspend_o, ref_clock_out_enable_o;
   logic [2:0] ee_addr_o;
   logic [15:0] cfg_word_o;
   logic skew_err;
   logic [15:0] exp_q[$];
   int failures = 0, checks_done = 0, seed = 32'hd183;
   always #2 clk_i = ~clk_i;
   ris_seq dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fundamental_reset_n_i(frst_n),
      .aux_power_on_reset_n_i(arst_n), .root_complex_mode_strap_i(strap),
      .ee_present_i(present), .ee_valid_i(ee_valid), .ee_data_i(ee_data),
      .sw_usb_enable_i(sw_usb), .sw_ref_clock_out_enable_i(sw_ref), .sw_ref_clock_wr_i(sw_wr),
      .usb_suspend_i(usb_susp), .d3cold_i(d3cold), .wake_i(wake), .ee_req_o(ee_req_o),
      .ee_addr_o(ee_addr_o), .root_complex_mode_o(root_complex_mode_o),
      .link_enum_enable_o(link_enum_enable_o), .usb_enum_enable_o(usb_enum_enable_o),
      .link_training_enable_o(link_training_enable_o), .config_ready_o(config_ready_o),
      .suspend_o(suspend_o), .ref_clock_out_enable_o(ref_clock_out_enable_o),
      .cfg_word_o(cfg_word_o), .reset_skew_err_o(skew_err));
   ris_board_model ee_u (.clk_i(clk_i), .slow_i(slow), .words_i(words), .ee_req_i(ee_req_o),
      .ee_addr_i(ee_addr_o), .ee_valid_o(ee_valid), .ee_data_o(ee_data));
   // ==========================================
   // Compare and closing
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   // ==========================================
   // Reset, strap capture and EEPROM load
   task automatic boot(input logic rc, input logic pr);
      int n;
      n = 0;
      // Let an edge pass so no pin is driven twice in one step
      @(negedge clk_i);
      frst_n = 1'b0;
      arst_n = 1'b0; // Both pins move together, no skew
      strap = rc;
      present = pr;
      slow = $random(seed);
      words = {$random(seed), $random(seed), $random(seed), $random(seed)};
      words[112] = rc;
      // Reference model: the words an attached EEPROM hands over, in order
      exp_q.delete();
      for (int w = 0; w < 8; w++) begin
         if (pr) exp_q.push_back(words[16*w +: 16]);
      end
      // Hold is shortened; the core only needs settled straps
      repeat (4) @(negedge clk_i);
      chk("reset ref clk", 16'h0001, ref_clock_out_enable_o);
      chk("reset outs", 16'h0000, {suspend_o, config_ready_o, cfg_word_o[13:0]});
      frst_n = 1'b1;
      arst_n = 1'b1;
      while (config_ready_o !== 1'b1 && n < 200) begin
         chk("early enable", 16'h0000, {link_training_enable_o, link_enum_enable_o});
         @(negedge clk_i);
         n++;
      end
      if (n >= 200) failures++;
      chk("mode", rc, root_complex_mode_o);
      chk("link enum", !rc, link_enum_enable_o);
      chk("usb enum", rc, usb_enum_enable_o);
      chk("link train", 16'h0001, link_training_enable_o);
      chk("cfg word", (exp_q.size() > 0) ? exp_q[$] : 16'h0000, cfg_word_o);
      chk("ref clk", (exp_q.size() > 0) ? exp_q[$][0] : 1'b1, ref_clock_out_enable_o);
      chk("load idle", 16'h0000, {skew_err, ee_req_o, ee_addr_o});
   endtask : boot
   // ==========================================
   // Main sequence
   initial begin
      repeat (10) @(negedge clk_i);
      sys_rst_i = 1'b0;
      for (int k = 0; k < 4; k++) begin
         boot(k[1], k[0]);
         sw_usb = 1'b1;
         repeat (2) @(negedge clk_i);
         chk("sw usb", 16'h0001, usb_enum_enable_o);
         sw_usb = 1'b0;
         sw_ref = 1'b0;
         sw_wr = 1'b1;
         @(negedge clk_i);
         sw_wr = 1'b0;
         chk("sw ref clk", 16'h0000, ref_clock_out_enable_o);
         // The request of the other mode must be ignored
         {usb_susp, d3cold} = k[1] ? 2'b01 : 2'b10;
         repeat (6) @(negedge clk_i);
         chk("no suspend", 16'h0000, suspend_o);
         {usb_susp, d3cold} = k[1] ? 2'b10 : 2'b01;
         repeat (6) @(negedge clk_i);
         chk("suspend", 16'h0001, suspend_o);
         if (k[0]) wake = 1'b1;
         else arst_n = 1'b0;
         repeat (4) @(negedge clk_i);
         chk("leave suspend", 16'h0000, suspend_o);
         {wake, usb_susp, d3cold} = 3'b000;
         arst_n = 1'b1;
         sw_ref = 1'b1;
      end
      // Fundamental pin alone low: core resets and the pins disagree
      frst_n = 1'b0;
      repeat (8) @(negedge clk_i);
      chk("fund only", 16'h0000, config_ready_o);
      chk("skew short", 16'h0000, skew_err);
      repeat (12) @(negedge clk_i);
      chk("skew long", 16'h0001, skew_err);
      frst_n = 1'b1;
      stop_test();
   end
   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #40000;
      failures++;
      stop_test();
   end
endmodule : reset_init_sequencer_bench
`default_nettype wire
